/* src/bcp_commutator.sv */
// Six-step sensorless commutation controller with APB registers.
// Assumes synchronous comparator inputs and an external gate driver bridge.
// Summary of operation
// - Step commutation state 0..5 in order, once per 60 degrees of rotor angle.
// - States 0-2 drive C-high/B-low, A-high/B-low, A-high/C-low; others off.
// - States 3-5 drive B-high/C-low, B-high/A-low, C-high/A-low; others off.
// - Each phase conducts 120 degrees; two phases driven, third left open.
// - Speed set by modulating high or low switch, scheme chosen by software.
// - High-side mode: only high gate modulated, low gate held on.
// - Low-side mode: only low gate modulated, high gate held on.
// - Complementary modes drive opposite switch of same leg with dead time.
// - Mixed mode alternates high and low modulation, one modulated gate at once.
// - Commutation timing comes from open-phase back-EMF zero crossing.
// - Commutate 30 electrical degrees after the detected crossing.
// - Open-phase sense is unreliable at start of each PWM off interval.
// - Crossing is a polarity change of open-terminal versus neutral comparator.
// - No crossing accepted while open-terminal current flows early in off time.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module bcp_commutator
  import bcp_pkg::*;
#(
  parameter int PWM_W = 16,
  parameter int CNT_W = 24,
  parameter int PWM_PERIOD_DEF = PWM_PERIOD_CYC,
  parameter int STARTUP_DEF = STARTUP_STEP_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [2:0] BEMF_CMP_I,
  output logic PHASE_A_HIGH_GATE_O,
  output logic PHASE_B_HIGH_GATE_O,
  output logic PHASE_C_HIGH_GATE_O,
  output logic PHASE_A_LOW_GATE_O,
  output logic PHASE_B_LOW_GATE_O,
  output logic PHASE_C_LOW_GATE_O
);
  initial begin
    if (PWM_W < 8 || PWM_W > 24 || CNT_W < 8 || CNT_W > 31) begin
      $error("bcp_commutator: unsupported widths");
    end
    if (PWM_PERIOD_DEF < 2 || PWM_PERIOD_DEF >= (1 << PWM_W)) begin
      $error("bcp_commutator: PWM period default out of range");
    end
    if (STARTUP_DEF < 2 || STARTUP_DEF >= (1 << CNT_W)) begin
      $error("bcp_commutator: startup step default out of range");
    end
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_ZC, ST_DELAY} bcp_run_type;

  // Conducting phases per step, 0 = A, 1 = B, 2 = C
  localparam logic [1:0] HI_PHASE [0:5] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  localparam logic [1:0] LO_PHASE [0:5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h0, 2'h0};

  // Registers
  logic en_r;
  logic [2:0] mode_r;
  logic [PWM_W-1:0] period_r;
  logic [PWM_W-1:0] duty_r;
  logic [7:0] dead_r;
  logic [15:0] blank_r;
  logic [CNT_W-1:0] startup_r;
  logic [CNT_W-1:0] interval_r;
  logic lock_r;
  logic step_req_r;
  bcp_run_type run_r;
  logic [2:0] step_r;
  logic [CNT_W-1:0] since_zc_r;
  logic [CNT_W-1:0] delay_r;
  logic [15:0] blank_cnt_r;
  logic prev_cmp_r;
  logic prev_ok_r;
  bcp_gate_type gate_r;

  // APB decode
  wire logic setup = PSEL_I && !PENABLE_I;
  wire logic wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  wire logic hit_ctrl = PADDR_I == OFS_CTRL;
  wire logic hit_period = PADDR_I == OFS_PERIOD;
  wire logic hit_duty = PADDR_I == OFS_DUTY;
  wire logic hit_dead = PADDR_I == OFS_DEAD;
  wire logic hit_blank = PADDR_I == OFS_BLANK;
  wire logic hit_startup = PADDR_I == OFS_STARTUP;
  wire logic hit_status = PADDR_I == OFS_STATUS;
  wire logic hit_interval = PADDR_I == OFS_INTERVAL;
  wire logic hit_any = hit_ctrl || hit_period || hit_duty || hit_dead || hit_blank
                    || hit_startup || hit_status || hit_interval;
  wire logic [31:0] ctrl_rd = {27'h0, 1'b0, mode_r, en_r};
  wire logic [31:0] status_rd = {27'h0, lock_r, run_r != ST_IDLE, step_r};
  wire logic [31:0] rd_data =
      hit_ctrl ? ctrl_rd :
      hit_period ? 32'(period_r) :
      hit_duty ? 32'(duty_r) :
      hit_dead ? {24'h0, dead_r} :
      hit_blank ? {16'h0, blank_r} :
      hit_startup ? 32'(startup_r) :
      hit_status ? status_rd :
      hit_interval ? 32'(interval_r) : 32'h0;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup && !hit_any;
      PRDATA_O <= (setup && !PWRITE_I) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      en_r <= 1'b0;
      mode_r <= MODE_RST;
      period_r <= PWM_W'(PWM_PERIOD_DEF);
      duty_r <= PWM_W'(DUTY_RST);
      dead_r <= 8'(DEAD_TIME_CYC);
      blank_r <= 16'(BLANK_CYC);
      startup_r <= CNT_W'(STARTUP_DEF);
      step_req_r <= 1'b0;
    end else begin
      step_req_r <= wr_en && hit_ctrl && PWDATA_I[CTRL_STEP_BIT];
      if (wr_en && hit_ctrl) begin
        en_r <= PWDATA_I[CTRL_EN_BIT];
        mode_r <= PWDATA_I[CTRL_MODE_LSB +: CTRL_MODE_W];
      end
      if (wr_en && hit_period) period_r <= PWDATA_I[PWM_W-1:0];
      if (wr_en && hit_duty) duty_r <= PWDATA_I[PWM_W-1:0];
      if (wr_en && hit_dead) dead_r <= PWDATA_I[7:0];
      if (wr_en && hit_blank) blank_r <= PWDATA_I[15:0];
      if (wr_en && hit_startup) startup_r <= PWDATA_I[CNT_W-1:0];
    end
  end

  // PWM carrier
  wire logic running = run_r != ST_IDLE;
  logic pwm_main;
  logic pwm_comp;
  logic pwm_off_start;

  bcp_pwm_gen #(.W(PWM_W), .DW(8)) u_pwm (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .en_i(running),
    .period_i(period_r),
    .duty_i(duty_r),
    .dead_i(dead_r),
    .main_o(pwm_main),
    .comp_o(pwm_comp),
    .off_start_o(pwm_off_start)
  );

  // Zero-crossing detection on the open phase
  wire logic [1:0] hi_ph = HI_PHASE[step_r];
  wire logic [1:0] lo_ph = LO_PHASE[step_r];
  wire logic [1:0] open_ph = 2'(2'h3 - hi_ph - lo_ph);
  wire logic cmp_open = BEMF_CMP_I[open_ph];
  wire logic cmp_rise = !step_r[0];
  wire logic blanked = pwm_off_start || blank_cnt_r != 16'h0;
  wire logic sample_ok = running && !blanked;
  wire logic zc_ok = sample_ok && run_r == ST_WAIT_ZC && prev_ok_r
                   && prev_cmp_r != cmp_rise && cmp_open == cmp_rise;
  wire logic timeout = run_r == ST_WAIT_ZC && since_zc_r >= startup_r - CNT_W'(1);
  wire logic delay_done = run_r == ST_DELAY && delay_r == '0;
  wire logic commutate = running && en_r && (step_req_r || timeout || delay_done);
  wire logic [2:0] step_nxt = step_r == LAST_STEP ? 3'h0 : step_r + 3'h1;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      blank_cnt_r <= 16'h0;
      prev_cmp_r <= 1'b0;
      prev_ok_r <= 1'b0;
    end else begin
      blank_cnt_r <= pwm_off_start ? blank_r
                   : (blank_cnt_r != 16'h0 ? blank_cnt_r - 16'h1 : blank_cnt_r);
      if (commutate || !running) begin
        prev_ok_r <= 1'b0;
      end else if (sample_ok) begin
        prev_ok_r <= 1'b1;
        prev_cmp_r <= cmp_open;
      end
    end
  end

  // Commutation sequencer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      run_r <= ST_IDLE;
      step_r <= 3'h0;
      since_zc_r <= '0;
      delay_r <= '0;
      interval_r <= '0;
      lock_r <= 1'b0;
    end else if (!en_r) begin
      run_r <= ST_IDLE;
      step_r <= 3'h0;
    end else begin
      unique case (run_r)
        ST_IDLE: begin
          run_r <= ST_WAIT_ZC;
          step_r <= 3'h0;
          since_zc_r <= '0;
          lock_r <= 1'b0;
        end
        ST_WAIT_ZC: begin
          since_zc_r <= since_zc_r + CNT_W'(1);
          if (commutate) begin
            step_r <= step_nxt;
            since_zc_r <= '0;
          end else if (zc_ok) begin
            interval_r <= since_zc_r;
            delay_r <= since_zc_r >> 1;
            since_zc_r <= '0;
            lock_r <= 1'b1;
            run_r <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          since_zc_r <= since_zc_r + CNT_W'(1);
          delay_r <= delay_r - CNT_W'(1);
          if (commutate) begin
            step_r <= step_nxt;
            run_r <= ST_WAIT_ZC;
          end
        end
      endcase
    end
  end

  // Gate pattern
  wire logic mode_ok = mode_r <= MODE_MIXED;
  wire logic mod_high = mode_r == MODE_HIGH || mode_r == MODE_CMP_HIGH
                     || (mode_r == MODE_MIXED && !step_r[0]);
  wire logic comp_mode = mode_r == MODE_CMP_HIGH || mode_r == MODE_CMP_LOW;
  wire logic hi_on = mod_high ? pwm_main : 1'b1;
  wire logic lo_on = mod_high ? 1'b1 : pwm_main;
  wire logic [2:0] hi_sel = 3'(3'h1 << hi_ph);
  wire logic [2:0] lo_sel = 3'(3'h1 << lo_ph);
  wire logic [2:0] hi_comp = (comp_mode && !mod_high && pwm_comp) ? lo_sel : 3'h0;
  wire logic [2:0] lo_comp = (comp_mode && mod_high && pwm_comp) ? hi_sel : 3'h0;
  wire bcp_gate_type gate_nxt = (running && en_r && mode_ok)
      ? '{hi: (hi_on ? hi_sel : 3'h0) | hi_comp, lo: (lo_on ? lo_sel : 3'h0) | lo_comp}
      : GATES_OFF;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      gate_r <= GATES_OFF;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  assign PHASE_A_HIGH_GATE_O = gate_r.hi[0];
  assign PHASE_B_HIGH_GATE_O = gate_r.hi[1];
  assign PHASE_C_HIGH_GATE_O = gate_r.hi[2];
  assign PHASE_A_LOW_GATE_O = gate_r.lo[0];
  assign PHASE_B_LOW_GATE_O = gate_r.lo[1];
  assign PHASE_C_LOW_GATE_O = gate_r.lo[2];

  // Checks
  property p_step_order;
    @(posedge CLK_I) disable iff (RST_I)
      (running && en_r && commutate) |=> (step_r == ($past(step_r) == LAST_STEP ? 3'h0
                                                    : $past(step_r) + 3'h1));
  endproperty
  a_step_order: assert property (p_step_order) else $error("Step order broken");

  property p_state0;
    @(posedge CLK_I) disable iff (RST_I)
      (gate_nxt != GATES_OFF && step_r == 3'h0 && mode_r == MODE_HIGH)
        |=> (gate_r.lo == 3'h2 && (gate_r.hi & 3'h3) == 3'h0);
  endproperty
  a_state0: assert property (p_state0) else $error("State 0 gate pattern wrong");

  property p_state3;
    @(posedge CLK_I) disable iff (RST_I)
      (gate_nxt != GATES_OFF && step_r == 3'h3 && mode_r == MODE_LOW)
        |=> (gate_r.hi == 3'h2 && (gate_r.lo & 3'h3) == 3'h0);
  endproperty
  a_state3: assert property (p_state3) else $error("State 3 gate pattern wrong");

  property p_two_phases;
    @(posedge CLK_I) disable iff (RST_I)
      !comp_mode |-> ##1 ($onehot0(gate_r.hi) && $onehot0(gate_r.lo)
                          && (gate_r.hi & gate_r.lo) == 3'h0);
  endproperty
  a_two_phases: assert property (p_two_phases) else $error("More than two phases driven");

  property p_high_mode;
    @(posedge CLK_I) disable iff (RST_I)
      (running && en_r && mode_r == MODE_HIGH && $stable(step_r)) |=> (gate_r.lo == $past(lo_sel));
  endproperty
  a_high_mode: assert property (p_high_mode) else $error("Low gate not held in high mode");

  property p_low_mode;
    @(posedge CLK_I) disable iff (RST_I)
      (running && en_r && mode_r == MODE_LOW && $stable(step_r)) |=> (gate_r.hi == $past(hi_sel));
  endproperty
  a_low_mode: assert property (p_low_mode) else $error("High gate not held in low mode");

  property p_no_shoot;
    @(posedge CLK_I) disable iff (RST_I) (gate_r.hi & gate_r.lo) == 3'h0;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("Both switches of one leg on");

  property p_mixed;
    @(posedge CLK_I) disable iff (RST_I)
      (running && en_r && mode_r == MODE_MIXED && step_r[0]) |=> (gate_r.hi == $past(hi_sel));
  endproperty
  a_mixed: assert property (p_mixed) else $error("Mixed mode odd step not low-modulated");

  property p_delay_half;
    @(posedge CLK_I) disable iff (RST_I)
      (zc_ok && !commutate && en_r) |=> (run_r == ST_DELAY && delay_r == ($past(since_zc_r) >> 1));
  endproperty
  a_delay_half: assert property (p_delay_half) else $error("30 degree delay wrong");

  property p_blank;
    @(posedge CLK_I) disable iff (RST_I) pwm_off_start |-> !zc_ok;
  endproperty
  a_blank: assert property (p_blank) else $error("Crossing accepted during blanking");

  property p_off_idle;
    @(posedge CLK_I) disable iff (RST_I) !en_r |=> ##1 (gate_r == GATES_OFF);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Gates on while disabled");

endmodule : bcp_commutator

/* src/bcp_pkg.sv */
// Package for the six-step block-commutation PWM controller.
// Assumes a 200 MHz system clock and an APB register port with 32-bit data.
package bcp_pkg;

  // Clock and timing
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int PWM_FREQ_HZ = 24_000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int DEAD_TIME_NS = 500;
  localparam int DEAD_TIME_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_NS = 2000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_STEP_US = 5000;
  localparam int STARTUP_STEP_CYC = STARTUP_STEP_US * CLK_MHZ;

  // Commutation sequence
  localparam int NUM_STEPS = 6;
  localparam logic [2:0] LAST_STEP = 3'h5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_DUTY = 8'h08;
  localparam logic [7:0] OFS_DEAD = 8'h0c;
  localparam logic [7:0] OFS_BLANK = 8'h10;
  localparam logic [7:0] OFS_STARTUP = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_INTERVAL = 8'h1c;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_W = 3;
  localparam int CTRL_STEP_BIT = 4;

  // Status register fields
  localparam int STAT_STEP_LSB = 0;
  localparam int STAT_RUN_BIT = 3;
  localparam int STAT_LOCK_BIT = 4;

  // Reset values
  localparam logic [15:0] DUTY_RST = 16'h0000;

  // Modulation schemes
  localparam logic [2:0] MODE_HIGH = 3'h0;
  localparam logic [2:0] MODE_LOW = 3'h1;
  localparam logic [2:0] MODE_CMP_HIGH = 3'h2;
  localparam logic [2:0] MODE_CMP_LOW = 3'h3;
  localparam logic [2:0] MODE_MIXED = 3'h4;
  localparam logic [2:0] MODE_RST = MODE_HIGH;

  // Gate bundle: bit 0 phase A, bit 1 phase B, bit 2 phase C
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } bcp_gate_type;

  localparam bcp_gate_type GATES_OFF = '{hi: 3'h0, lo: 3'h0};

endpackage : bcp_pkg

/* src/bcp_pwm_gen.sv */
// PWM carrier with dead-timed main and complementary outputs.
// Assumes period and duty are held steady by software between updates.
`timescale 1ns/1ps
module bcp_pwm_gen #(
  parameter int W = 16,
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [W-1:0] period_i,
  input wire logic [W-1:0] duty_i,
  input wire logic [DW-1:0] dead_i,
  output logic main_o,
  output logic comp_o,
  output logic off_start_o
);
  initial begin
    if (W < 4 || W > 24 || DW < 1 || DW > W) begin
      $error("bcp_pwm_gen: unsupported widths");
    end
  end

  logic [W-1:0] cnt_r;
  logic [DW-1:0] dead_r;
  logic raw_r;
  wire logic wrap = (cnt_r >= period_i - W'(1));
  wire logic raw_nxt = en_i && (cnt_r < duty_i);
  wire logic edge_seen = raw_nxt != raw_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_r <= '0;
      raw_r <= 1'b0;
      dead_r <= '0;
      main_o <= 1'b0;
      comp_o <= 1'b0;
      off_start_o <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + W'(1);
      raw_r <= raw_nxt;
      dead_r <= edge_seen ? dead_i : (dead_r != '0 ? dead_r - DW'(1) : dead_r);
      main_o <= raw_nxt && !edge_seen && dead_r == '0;
      comp_o <= !raw_nxt && !edge_seen && dead_r == '0;
      off_start_o <= raw_r && !raw_nxt;
    end
  end

  property p_no_overlap;
    @(posedge clk_i) disable iff (rst_i) !(main_o && comp_o);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("PWM main and complement overlap");

endmodule : bcp_pwm_gen

/* verification/bcp_bridge_model.sv */
// Bridge and rotor model: comparator levels of a free-running rotor, gate monitors.
// Assumes gate commands from the controller on the shared clock.
`timescale 1ns/1ps
module bcp_bridge_model
  import bcp_pkg::*;
#(
  parameter int SEG = 200
) (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic clr_i,
  input wire bcp_gate_type gate_i,
  output logic [2:0] cmp_o,
  output int ang_o,
  output int on_cnt_o [6],
  output int shoot_o,
  output int gap_o
);
  int off_cnt [3];
  int noise = 0;
  logic [2:0] last_hi;
  bcp_gate_type prev = GATES_OFF;
  // Terminal above virtual neutral; each phase crosses 30 degrees into its open sectors, rising in one and falling in the other
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      cmp_o[k] = ((ang_o + 23 * SEG / 2 - 2 * k * SEG) % (6 * SEG) < 3 * SEG)
        ^ (noise > 0);
    end
  end
  always @(posedge clk_i) begin
    if (run_i) begin
      ang_o <= (ang_o + 1) % (6 * SEG);
    end
    // Open-terminal current when PWM turns the high side off, low side unchanged
    noise <= (prev.hi != 3'h0 && gate_i.hi == 3'h0 && gate_i.lo == prev.lo) ? 2
           : (noise > 0 ? noise - 1 : 0);
    prev = gate_i;
    for (int k = 0; k < 3; k++) begin
      if (gate_i.hi[k] && gate_i.lo[k]) shoot_o = shoot_o + 1;
      if (gate_i.hi[k] != gate_i.lo[k] && off_cnt[k] > 0 && gate_i.hi[k] !== last_hi[k])
        gap_o = (off_cnt[k] < gap_o) ? off_cnt[k] : gap_o;
      if (gate_i.hi[k] || gate_i.lo[k]) last_hi[k] = gate_i.hi[k];
      off_cnt[k] = (gate_i.hi[k] || gate_i.lo[k]) ? 0 : off_cnt[k] + 1;
      on_cnt_o[k] = clr_i ? 0 : on_cnt_o[k] + gate_i.lo[k];
      on_cnt_o[k + 3] = clr_i ? 0 : on_cnt_o[k + 3] + gate_i.hi[k];
    end
    if (clr_i) gap_o = 1000;
  end
endmodule : bcp_bridge_model

/* verification/bcp_commutator_bench.sv */
// Testbench of the commutation controller: APB master, bridge model, checks.
// Assumes the controller ports as declared and a 200 MHz clock.
`timescale 1ns/1ps
module bcp_commutator_bench
  import bcp_pkg::*;
;
  localparam int PER = 20;
  localparam int SEG = 200;
  localparam int DT = 2;
  localparam logic [2:0] HI_T [6] = '{3'h4, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4};
  localparam logic [2:0] LO_T [6] = '{3'h2, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1};
  localparam logic [2:0] B_MODES [3] = '{MODE_HIGH, MODE_LOW, MODE_MIXED};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic run = 1'b0;
  logic clr = 1'b0;
  logic [2:0] cmp;
  wire bcp_gate_type gates;
  int ang, shoot, gap;
  int on_cnt [6];
  int fail_count = 0;
  int checks = 0;
  logic [31:0] seed = 32'hd9a7;
  bcp_commutator #(.PWM_PERIOD_DEF(PER), .STARTUP_DEF(SEG)) dut_u (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .BEMF_CMP_I(cmp),
    .PHASE_A_HIGH_GATE_O(gates.hi[0]), .PHASE_B_HIGH_GATE_O(gates.hi[1]),
    .PHASE_C_HIGH_GATE_O(gates.hi[2]), .PHASE_A_LOW_GATE_O(gates.lo[0]),
    .PHASE_B_LOW_GATE_O(gates.lo[1]), .PHASE_C_LOW_GATE_O(gates.lo[2])
  );
  bcp_bridge_model #(.SEG(SEG)) bridge_u (
    .clk_i(clk), .run_i(run), .clr_i(clr), .gate_i(gates), .cmp_o(cmp), .ang_o(ang),
    .on_cnt_o(on_cnt), .shoot_o(shoot), .gap_o(gap)
  );
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [31:0] ctrl(input logic [2:0] m, input logic en, input logic st);
    return {27'h0, st, m, en};
  endfunction : ctrl
  task automatic cmp_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h to %h", $time, got, lo, hi);
    end
  endtask : cmp_rng
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : apb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic err_exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    cmp_rng(rd, exp, exp);
    cmp_rng({31'h0, err}, {31'h0, err_exp}, {31'h0, err_exp});
  endtask : rchk
  task automatic gchk(input bcp_gate_type exp);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp_rng({26'h0, gates}, {26'h0, exp}, {26'h0, exp});
  endtask : gchk
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    bcp_gate_type g;
    logic [5:0] modm, heldm, compm;
    logic hs;
    logic [2:0] m;
    int d, k;
    logic [31:0] rd;
    logic err;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    gchk(GATES_OFF);
    rchk(OFS_CTRL, 32'h0, 1'b0);
    rchk(OFS_DUTY, {16'h0, DUTY_RST}, 1'b0);
    wreg(OFS_STATUS, 32'h1f);
    rchk(OFS_STATUS, 32'h0, 1'b0);
    rchk(8'h20, 32'h0, 1'b1);
    wreg(OFS_DEAD, DT);
    wreg(OFS_BLANK, 32'h4);
    wreg(OFS_STARTUP, 32'h00ff_ffff);
    foreach (B_MODES[i]) begin
      m = B_MODES[i];
      wreg(OFS_CTRL, ctrl(m, 1'b1, 1'b0));
      for (int s = 0; s < 7; s++) begin
        g = '{hi: HI_T[s % 6], lo: LO_T[s % 6]};
        if (m == MODE_LOW || (m == MODE_MIXED && s % 2 == 1)) g.lo = 3'h0;
        else g.hi = 3'h0;
        gchk(g);
        rchk(OFS_STATUS, 32'h8 | (s % 6), 1'b0);
        wreg(OFS_CTRL, ctrl(m, 1'b1, 1'b1));
      end
      wreg(OFS_CTRL, ctrl(m, 1'b0, 1'b0));
      gchk(GATES_OFF);
    end
    for (int i = 0; i < 5; i++) begin
      m = i[2:0];
      seed = lfsr(seed);
      k = seed % 6;
      d = 6 + (seed >> 8) % (PER - 11);
      wreg(OFS_DUTY, d);
      wreg(OFS_CTRL, ctrl(m, 1'b1, 1'b0));
      for (int j = 0; j < k; j++) wreg(OFS_CTRL, ctrl(m, 1'b1, 1'b1));
      g = '{hi: HI_T[k], lo: LO_T[k]};
      hs = m == MODE_HIGH || m == MODE_CMP_HIGH || (m == MODE_MIXED && k % 2 == 0);
      modm = hs ? {g.hi, 3'h0} : {3'h0, g.lo};
      heldm = hs ? {3'h0, g.lo} : {g.hi, 3'h0};
      compm = (m == MODE_CMP_HIGH || m == MODE_CMP_LOW) ? {modm[2:0], modm[5:3]} : 6'h0;
      repeat (3 * PER) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (10 * PER) @(posedge clk);
      @(negedge clk);
      for (int j = 0; j < 6; j++) begin
        if (heldm[j]) cmp_rng(on_cnt[j], 10 * PER, 10 * PER);
        else if (modm[j]) cmp_rng(on_cnt[j], 10 * (d - 2 * DT - 1), 10 * (d + 1));
        else if (compm[j]) cmp_rng(on_cnt[j], 10 * (PER - d - 2 * DT - 1), 10 * (PER - d + 1));
        else cmp_rng(on_cnt[j], 0, 0);
      end
      if (compm != 6'h0) cmp_rng(gap, DT, PER);
      wreg(OFS_CTRL, ctrl(m, 1'b0, 1'b0));
    end
    wreg(OFS_DUTY, PER / 2);
    wreg(OFS_STARTUP, 7 * SEG);
    run <= 1'b1;
    wreg(OFS_CTRL, ctrl(MODE_HIGH, 1'b1, 1'b0));
    repeat (6000) @(posedge clk);
    for (int s = 0; s < 6; s++) begin
      k = 0;
      while (ang != s * SEG + SEG / 2 && k < 2000) begin
        @(negedge clk);
        k++;
      end
      if (k >= 2000) fail_count++;
      rchk(OFS_STATUS, 32'h18 | s, 1'b0);
      apb(1'b0, OFS_INTERVAL, 32'h0, rd, err);
      cmp_rng(rd, SEG - 8, SEG + 8);
    end
    wreg(OFS_CTRL, 32'h0);
    gchk(GATES_OFF);
    cmp_rng(shoot, 0, 0);
    tally_and_finish();
  end
endmodule : bcp_commutator_bench
